// File: rtl/ivd_defines.vh
// Constants for the interrupt vector dispatch block
`ifndef IVD_DEFINES_VH
`define IVD_DEFINES_VH
// Dispatch offsets
`define OFS_EMU_START     16'h00c8
`define OFS_EMU_CONT      16'h00cc
`define OFS_SOFT2         16'h0088
`define OFS_SOFT3         16'h008c
`define OFS_STORE1        16'h0108
`define OFS_STORE2        16'h0104
`define OFS_EXT_MIN       16'h0100
`define OFS_EXT_MAX       16'hfffc
// Priority levels
`define IPL_LINE3         5'h17
`define IPL_LINE2         5'h16
`define IPL_LINE1         5'h15
`define IPL_LINE0         5'h14
`define IPL_FORCED        5'h17
`define IPL_STORE         5'h14
`define IPL_NONE          5'h00
// Parameter counts
`define PARAMS_EMU_START  4'ha
`define PARAMS_NONE       4'h0
// Identification register
`define IDENT_REG_NUM     6'h3e
`define IDENT_TYPE_CODE   8'h5a
`define IDENT_UCODE_REV   8'h01
`define IDENT_RESERVED    16'h0000
// External vector fields
`define VEC_FORCE_BIT     0
`define VEC_IDX_HI        15
`define VEC_IDX_LO        2
// Source select codes
`define SRC_EXT           3'h0
`define SRC_STORE1        3'h1
`define SRC_STORE2        3'h2
`define SRC_SOFT3         3'h3
`define SRC_SOFT2         3'h4
`define SRC_EMU           3'h5
// Shared fill values
`define ZERO_WORD         32'h00000000
`define VEC_ALIGN_PAD     2'h0
`define NO_LINES          4'h0
`endif

// File: rtl/ext_level_decode.v
// Priority level decode for external bus interrupts
`timescale 1ns/1ps
`include "ivd_defines.vh"
module ext_level_decode (
  // Request and vector
  input  wire [3:0]  irqLines,
  input  wire        forceBit,
  // Result
  output reg  [4:0]  level,
  output reg  [1:0]  lineServiced
);
  // Highest active line wins; the forcing bit overrides the line
  always @* begin
    lineServiced = 2'h0;
    level = `IPL_LINE0;                              // RULE_04
    if (irqLines[3]) begin
      lineServiced = 2'h3;
      level = `IPL_LINE3;                            // RULE_04
    end else if (irqLines[2]) begin
      lineServiced = 2'h2;
      level = `IPL_LINE2;                            // RULE_04
    end else if (irqLines[1]) begin
      lineServiced = 2'h1;
      level = `IPL_LINE1;                            // RULE_04
    end
    if (forceBit) begin
      level = `IPL_FORCED;                           // RULE_05
    end
  end
endmodule

// File: rtl/interrupt_vector_dispatch.v
// Interrupt and exception dispatch with identification register
`timescale 1ns/1ps
`include "ivd_defines.vh"
// How it works
// RULE_01: External interrupts use offsets 100 to FFFC; the code also dispatches lower offsets and sets vectorError
// RULE_02: Table index from vector bits 15:2
// RULE_03: Level from request line or bit 0
// RULE_04: Bit 0 clear: lines 3..0 give 17..14
// RULE_05: Bit 0 set forces level 17
// RULE_06: Service routine fixes level after forcing
// RULE_07: External devices supply vectors 100 to FFFC
// RULE_08: Emulation start: C8, ten parameters
// RULE_09: Emulation continue: CC, no parameters
// RULE_10: First storage port: 108, level 14
// RULE_11: Second storage port: 104, level 14
// RULE_12: Software level 2: offset 88
// RULE_13: Software level 3: offset 8C
// RULE_14: Read-only 32-bit ident at register 62
// RULE_15: Ident bits 31:24 give type code
// RULE_16: Ident bits 23:8 reserved, read-only
// RULE_17: Ident bits 7:0 give microcode revision
// RULE_18: Flag set at start reports via CC
// RULE_19: Every dispatch offset is longword aligned
module interrupt_vector_dispatch (
  // Clock and reset
  input  wire        ref_clk,
  input  wire        rst,
  // External bus interrupt
  input  wire        extReq,
  input  wire [3:0]  irqLines,
  input  wire [15:0] extVector,
  // Internal sources
  input  wire        storeReq1,
  input  wire        storeReq2,
  input  wire        softReq2,
  input  wire        softReq3,
  input  wire        emuReq,
  input  wire        firstPartDone,
  input  wire [31:0] emuPc,
  // Privileged register read
  input  wire        regRead,
  input  wire [5:0]  regNum,
  // Dispatch result
  output reg         dispatchValid,
  output reg  [15:0] dispatchOffset,
  output reg  [4:0]  newLevel,
  output reg         levelChange,
  output reg  [3:0]  paramCount,
  output reg  [31:0] savedPc,
  output reg         vectorError,
  // Register read result
  output reg         readValid,
  output reg         readHit,
  output reg  [31:0] readData
);
  // Decoded external level and aligned table offset
  wire [4:0]  extLevel;
  wire [15:0] extOffset;
  wire        extInRange;
  // Winning source and the values it dispatches with
  reg  [2:0]  source;
  reg         anyReq;
  reg  [15:0] next_offset;
  reg  [4:0]  next_level;
  reg         next_levelChange;
  reg  [3:0]  next_params;
  reg         next_error;
  reg  [31:0] next_savedPc;
  // Register read path
  wire [31:0] identValue;
  wire        identMatch;
  reg         next_readHit;
  reg  [31:0] next_readData;

  // Line decode kept apart; the serviced line is not exported because
  // a forced level hides it anyway and software has to find it itself
  ext_level_decode levelDecode (
    .irqLines     (irqLines),
    .forceBit     (extVector[`VEC_FORCE_BIT]),   // RULE_03
    .level        (extLevel),
    .lineServiced ()
  );

  // Index bits kept, low two cleared so entries stay longword aligned
  assign extOffset = {extVector[`VEC_IDX_HI:`VEC_IDX_LO], `VEC_ALIGN_PAD}; // RULE_02 RULE_19
  // Vectors below 100 are flagged; devices are expected to stay in range
  assign extInRange = (extOffset >= `OFS_EXT_MIN) && (extOffset <= `OFS_EXT_MAX); // RULE_01 RULE_07

  // Ident value is fixed; reserved field reads as zero
  assign identValue = {`IDENT_TYPE_CODE, `IDENT_RESERVED, `IDENT_UCODE_REV}; // RULE_15 RULE_16 RULE_17
  // Only one register number decodes; the rest answer with a miss
  assign identMatch = (regNum == `IDENT_REG_NUM);                  // RULE_14

  // Source priority: exceptions first, then highest level interrupts
  // Bus request with no line raised is ignored, not dispatched
  // Emulation and bus request together: emulation wins and the level
  // held bus request is simply taken again on a later cycle
  always @* begin
    anyReq = 1'h1;
    source = `SRC_EXT;
    if (emuReq) begin
      source = `SRC_EMU;
    end else if (extReq && (irqLines != `NO_LINES)) begin
      source = `SRC_EXT;
    end else if (storeReq1) begin
      source = `SRC_STORE1;
    end else if (storeReq2) begin
      source = `SRC_STORE2;
    end else if (softReq3) begin
      source = `SRC_SOFT3;
    end else if (softReq2) begin
      source = `SRC_SOFT2;
    end else begin
      anyReq = 1'h0;
    end
  end

  // Offset, level and parameter count for the selected source
  always @* begin
    next_offset = `OFS_EXT_MIN;
    next_level = `IPL_NONE;
    next_levelChange = 1'h0;
    next_params = `PARAMS_NONE;
    next_error = 1'h0;
    next_savedPc = savedPc;
    case (source)
      `SRC_EXT: begin
        // Level from the line or forced; out of range still dispatched
        next_offset = extOffset;                     // RULE_01
        next_level = extLevel;                       // RULE_03
        next_levelChange = 1'h1;
        next_error = ~extInRange;
      end
      // Storage ports share one level; the offset tells them apart
      `SRC_STORE1: begin
        next_offset = `OFS_STORE1;                   // RULE_10
        next_level = `IPL_STORE;                     // RULE_10
        next_levelChange = 1'h1;
      end
      `SRC_STORE2: begin
        next_offset = `OFS_STORE2;                   // RULE_11
        next_level = `IPL_STORE;                     // RULE_11
        next_levelChange = 1'h1;
      end
      `SRC_SOFT3: begin
        // Level stays; the handler raises it in software
        next_offset = `OFS_SOFT3;                    // RULE_13
      end
      `SRC_SOFT2: begin
        // Usually delivers asynchronous_system_trap work
        next_offset = `OFS_SOFT2;                    // RULE_12
      end
      `SRC_EMU: begin
        // Same mode fault, so the level is left alone
        // Saved PC points at the opcode of the emulated instruction
        next_savedPc = emuPc;                        // RULE_18
        if (firstPartDone) begin
          next_offset = `OFS_EMU_CONT;               // RULE_09 RULE_18
          next_params = `PARAMS_NONE;                // RULE_09
        end else begin
          next_offset = `OFS_EMU_START;              // RULE_08
          next_params = `PARAMS_EMU_START;           // RULE_08
        end
      end
      default: begin
        // Unused codes fall back to the lowest external entry
        next_offset = `OFS_EXT_MIN;
      end
    endcase
  end

  // Dispatch register: one-cycle valid pulse per taken request
  // Results hold between requests so a late reader still sees them
  always @(posedge ref_clk) begin
    if (rst) begin
      dispatchValid <= 1'h0;
      dispatchOffset <= `OFS_EXT_MIN;
      newLevel <= `IPL_NONE;
      levelChange <= 1'h0;
      paramCount <= `PARAMS_NONE;
      savedPc <= `ZERO_WORD;
      vectorError <= 1'h0;
    end else begin
      dispatchValid <= anyReq;
      if (anyReq) begin
        dispatchOffset <= next_offset;
        newLevel <= next_level;
        levelChange <= next_levelChange;
        // Parameter count tells the handler how many longwords were pushed
        paramCount <= next_params;
        vectorError <= next_error;
        savedPc <= next_savedPc;                     // RULE_18
      end
    end
  end

  // Read answer; a miss returns zero rather than stale data
  // Number compare is exact, so nearby numbers never alias
  always @* begin
    next_readHit = 1'h0;
    next_readData = `ZERO_WORD;
    if (identMatch) begin
      next_readHit = 1'h1;                           // RULE_14
      next_readData = identValue;                    // RULE_15 RULE_16 RULE_17
    end
  end

  // Read result register; nothing can write it, so it stays read-only
  // Valid pulses for every read, hit or miss
  always @(posedge ref_clk) begin
    if (rst) begin
      readValid <= 1'h0;
      readHit <= 1'h0;
      readData <= `ZERO_WORD;
    end else begin
      readValid <= regRead;
      if (regRead) begin
        readHit <= next_readHit;                     // RULE_14
        readData <= next_readData;                   // RULE_14
      end
    end
  end
endmodule

// File: dv/ivd_monitor.sv
// Dispatch checker bound to the block
`timescale 1ns/1ps
module ivd_monitor (
  // Watched ports
  input wire        ref_clk,
  input wire        rst,
  input wire        extReq,
  input wire [3:0]  irqLines,
  input wire [15:0] extVector,
  input wire        emuReq,
  input wire        firstPartDone,
  input wire        dispatchValid,
  input wire [15:0] dispatchOffset,
  input wire [4:0]  newLevel,
  input wire        vectorError
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Bus request counts only while emulation is idle
  wire take = extReq && |irqLines && !emuReq;
  ext_idx_a: assert property (take |=> dispatchOffset == ($past(extVector) & 16'hfffc)) else $error("idx");
  low_vec_a: assert property (take |=> vectorError == ($past(extVector) < 16'h0100)) else $error("range");
  forced_lvl_a: assert property (take && extVector[0] |=> newLevel == 5'h17) else $error("force");
  top_line_a: assert property (take && !extVector[0] && irqLines[3] |=> newLevel == 5'h17)
    else $error("top line");
  low_line_a: assert property (take && !extVector[0] && irqLines == 4'h1 |=> newLevel == 5'h14)
    else $error("low line");
  emu_start_a: assert property (emuReq && !firstPartDone |=> dispatchOffset == 16'h00c8)
    else $error("start");
  emu_cont_a: assert property (emuReq && firstPartDone |=> dispatchOffset == 16'h00cc)
    else $error("cont");
  offset_aligned_a: assert property (dispatchValid |-> dispatchOffset[1:0] == 2'h0) else $error("align");
endmodule
// Attach to the block
bind interrupt_vector_dispatch ivd_monitor i_mon (.*);

// File: dv/ext_irq_source.sv
// External bus interrupt source model
`timescale 1ns/1ps
module ext_irq_source (
  // Bus side
  output reg        extReq = 1'b0,
  output reg [3:0]  irqLines = 4'h0,
  output reg [15:0] extVector = 16'h0100
);
  // Released vector flips, so stale data never looks valid
  task set(input on, input [3:0] l, input [15:0] v);
    extReq = on;
    irqLines = l;
    extVector = on ? v : ~extVector;
  endtask
endmodule

// File: dv/testbench.sv
// Self-checking bench for the dispatch block
`timescale 1ns/1ps
`include "ivd_defines.vh"
module testbench;
  // Stimulus and results
  reg ref_clk = 1'b0, rst = 1'b1, regRead = 1'b0, firstPartDone = 1'b0, emuReq = 1'b0;
  reg storeReq1 = 1'b0, storeReq2 = 1'b0, softReq3 = 1'b0, softReq2 = 1'b0;
  reg [5:0] regNum = 6'h0;
  reg [31:0] emuPc = 32'h80001234;
  wire extReq, dispatchValid, levelChange, vectorError, readValid, readHit;
  wire [3:0] irqLines, paramCount;
  wire [15:0] extVector, dispatchOffset;
  wire [4:0] newLevel;
  wire [31:0] savedPc, readData;
  integer num_errors = 0, samples_checked = 0, i;
  // 25 MHz clock
  initial forever #20 ref_clk = ~ref_clk;
  ext_irq_source i_src (.extReq(extReq), .irqLines(irqLines), .extVector(extVector));
  interrupt_vector_dispatch i_dut (.*);
  // Case equality, so an unknown never matches
  task chk(input [39:0] g, e);
    samples_checked = samples_checked + 1;
    if (g !== e) begin
      num_errors = num_errors + 1;
      $display("mismatch at %0t: %h not %h", $time, g, e);
    end
  endtask
  task final_report;
    $display("%0d checks %0d mismatches", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // One request cycle; the answer stands one cycle after the take
  task go(input [3:0] l, input [15:0] v, input [5:0] m, input [20:0] e);
    @(negedge ref_clk);
    i_src.set(|l, l, v);
    {firstPartDone, emuReq, storeReq1, storeReq2, softReq3, softReq2} = m;
    @(negedge ref_clk);
    i_src.set(1'b0, 4'h0, v);
    {firstPartDone, emuReq, storeReq1, storeReq2, softReq3, softReq2} = 6'h0;
    chk({dispatchValid, newLevel, dispatchOffset}, {1'b1, e});
  endtask
  // Each line alone, stacked lines, forced level, range edges
  task t_ext;
    for (i = 0; i < 4; i = i + 1)
      go(4'h1 << i, 16'h0100 + 16'h4 * i, 6'h0, 21'h140100 + 21'h010004 * i);
    go(4'h6, 16'hfffc, 6'h0, 21'h16fffc);
    chk(vectorError, 0);
    go(4'h1, 16'h0201, 6'h0, 21'h170200);
    go(4'h2, 16'h00f0, 6'h0, 21'h1500f0);
    chk({levelChange, vectorError}, 2'h3);
    $display("t_ext done");
  endtask
  // Storage ports, software levels, emulation over the bus
  task t_int;
    go(4'h0, 16'h0, 6'h0c, 21'h140108);
    go(4'h0, 16'h0, 6'h04, 21'h140104);
    go(4'h0, 16'h0, 6'h01, 21'h000088);
    chk(levelChange, 1'h0);
    go(4'h0, 16'h0, 6'h02, 21'h00008c);
    go(4'h8, 16'h4320, 6'h10, 21'h0000c8);
    chk(paramCount, 4'ha);
    go(4'h0, 16'h0, 6'h30, 21'h0000cc);
    chk({paramCount, savedPc}, 36'h080001234);
    $display("t_int done");
  endtask
  // Reset mid-run with a bus request pending: reset wins
  task t_rst;
    @(negedge ref_clk);
    i_src.set(1'h1, 4'h8, 16'h0300);
    rst = 1'h1;
    @(negedge ref_clk);
    chk({dispatchValid, newLevel, dispatchOffset, paramCount}, {1'h0, `IPL_NONE, `OFS_EXT_MIN, `PARAMS_NONE});
    chk(savedPc, 0);
    i_src.set(1'h0, 4'h0, 16'h0);
    rst = 1'h0;
    $display("t_rst done");
  endtask
  // Ident read back to back with an unmapped number
  task t_reg;
    @(negedge ref_clk);
    regRead = 1'b1;
    regNum = 6'h3e;
    @(negedge ref_clk);
    regNum = 6'h3d;
    chk({readHit, readData}, {1'b1, `IDENT_TYPE_CODE, 16'h0, `IDENT_UCODE_REV});
    @(negedge ref_clk);
    regRead = 1'b0;
    chk({readValid, readHit, readData}, 34'h200000000);
    $display("t_reg done");
  endtask
  // Twelve cycles of reset, then the scenarios
  initial begin
    repeat (12) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 1'b0;
    t_ext;
    t_int;
    t_rst;
    t_reg;
    final_report;
  end
endmodule
